// ===== src/fms_pkg.sv
// Constants and types shared by the fail mode supervisor
package fms_pkg;
	// Core clock rate
	localparam int CLK_MHZ = 125;
	// Fail request deglitch, least time
	localparam int LIMP_DGL_US = 200;
	localparam int LIMP_DGL_CYC = LIMP_DGL_US * CLK_MHZ;
	localparam int DGL_W = 15;
	// Link watchdog timeouts, nominal
	localparam int WD_SHORT_MS = 32;
	localparam int WD_LONG_MS = 128;
	localparam int WD_SHORT_CYC = WD_SHORT_MS * 1000 * CLK_MHZ;
	localparam int WD_LONG_CYC = WD_LONG_MS * 1000 * CLK_MHZ;
	localparam int WD_W = 24;
	// Frame geometry
	localparam int WORD_W = 16;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam int WD_POS = 15;
	// Device status word (register 7) layout
	localparam int ST_FLAG = 0;
	localparam int ST_LIMP = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_FLT_LO = 3;
	localparam int NUM_FLT = 8;
	localparam int ST_PAD = WORD_W - ST_FLT_LO - NUM_FLT;
	// Channel counts
	localparam int NUM_CH = 5;
	localparam int NUM_IN = 4;
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_NORMAL = 2'h1,
		MODE_FAIL = 2'h2
	} fms_mode_t;
endpackage : fms_pkg

// ===== src/fms_supervisor.sv
// Fail mode supervisor: wake report, supply loss, link watchdog, mode
// Operation
// - Reset pin low, awake, not woken by reset pin: drive clock pin high
// - Asleep or woken by reset pin: clock pin stays undriven input
// - No serial readout while logic supply is absent
// - Both supplies lost: power off, channel, external switch and clock pin outputs off, state cleared
// - Battery lost, logic kept: keep state, channels off, external follows setting
// - Wake during battery loss is not shown on clock pin
// - Logic supply lost: link stops, watchdog timeout follows
// - Ground loss switches channels one to five off
// - Normal mode: channels follow internal PWM from the pwm_channels inputs
// - Status reports the eight fault types over the link
// - Fail request input high enters Fail mode
// - Fail mode: channels one to four follow their direct inputs, channel five stays off
// - Status register seven shows present fail request level
// - Any link fault moves Normal mode into Fail mode
// - Frame without inverted watchdog toggle bit is a link fault
// - Watchdog expiry before a valid frame is a link fault
// - Edge count per chip select not multiple of 16 is a fault
// - Link fault sets fault flag, reported in next transfer
// - Fault flag not cleared while in Fail mode, but still set by a link fault
// - Fault flag cleared on passing from Fail to Normal
// - Fail request acts only after staying high past 200 us
// - Watchdog timeout 32 ms with select low, 128 ms with select high
`timescale 1ns/1ps
module fms_supervisor #(
	parameter int NUM_CH = fms_pkg::NUM_CH,
	parameter int NUM_IN = fms_pkg::NUM_IN,
	parameter int LIMP_DGL_CYC = fms_pkg::LIMP_DGL_CYC,
	parameter int WD_SHORT_CYC = fms_pkg::WD_SHORT_CYC,
	parameter int WD_LONG_CYC = fms_pkg::WD_LONG_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic active_low_reset_pin_n,
	input wire logic wake_state,
	input wire logic wake_by_reset,
	input wire logic battery_supply_ok,
	input wire logic logic_supply_ok,
	input wire logic ground_ok,
	input wire logic limp_request,
	input wire logic [NUM_IN-1:0] direct_channel_inputs,
	input wire logic [NUM_CH-1:0] pwm_channels,
	input wire logic ext_switch_setting,
	input wire logic watchdog_period_select,
	input wire logic [fms_pkg::NUM_FLT-1:0] fault_types,
	output logic [NUM_CH-1:0] power_channel_outputs,
	output logic external_switch_drive,
	output logic wake_clk_o,
	output logic wake_clk_oe,
	output logic link_fault_flag,
	output logic fail_mode,
	output logic limp_status,
	output logic power_off
);

	localparam int PW = NUM_IN + 8;
	localparam int WW = fms_pkg::WD_W;
	localparam int DW = fms_pkg::DGL_W;
	localparam int CW = fms_pkg::CNT_W;
	localparam int SW = fms_pkg::WORD_W;
	localparam logic [WW-1:0] WD_SHORT_END = WW'(WD_SHORT_CYC - 1);
	localparam logic [WW-1:0] WD_LONG_END = WW'(WD_LONG_CYC - 1);
	localparam logic [DW-1:0] DGL_END = DW'(LIMP_DGL_CYC - 1);

	// Link side, clocked by the serial clock
	logic first_ff;
	logic [CW-1:0] cnt_ff;
	logic [SW-1:0] rx_ff;
	logic tog_ff;
	logic sdo_ff;
	logic [CW-1:0] nxt_cnt;
	logic [SW-1:0] nxt_rx;
	logic nxt_tog;
	logic sclk_arst_n;

	// Core side
	logic [PW-1:0] sync1_ff;
	logic [PW-1:0] sync2_ff;
	logic tog_s1_ff;
	logic tog_s2_ff;
	logic tog_seen_ff;
	logic cs_d_ff;
	logic [SW-1:0] stat_ff;
	fms_pkg::fms_mode_t mode_ff;
	fms_pkg::fms_mode_t nxt_mode;
	logic flag_ff;
	logic nxt_flag;
	logic ref_ff;
	logic have_ref_ff;
	logic [WW-1:0] wd_ff;
	logic [WW-1:0] nxt_wd;
	logic [DW-1:0] dgl_ff;
	logic [DW-1:0] nxt_dgl;
	logic limp_filt_ff;
	logic nxt_limp_filt;
	logic [NUM_CH-1:0] ch_ff;
	logic ext_ff;
	logic clk_oe_ff;
	logic sdo_oe_ff;
	logic fail_ff;
	logic limp_st_ff;
	logic off_ff;

	// Frame start clears the link counters without an edge to spare;
	// the chip select acts as an asynchronous preset of the frame flag.
	assign sclk_arst_n = arst_n & ~spi_cs_n;
	assign nxt_cnt = first_ff ? fms_pkg::CNT_ONE : cnt_ff + fms_pkg::CNT_ONE;
	assign nxt_rx = {rx_ff[SW-2:0], spi_sdi};
	assign nxt_tog = tog_ff ^ first_ff;

	always_ff @(posedge spi_sclk or negedge sclk_arst_n) begin
		if (!sclk_arst_n) begin
			first_ff <= 1'b1;
		end else begin
			first_ff <= 1'b0;
		end
	end

	always_ff @(posedge spi_sclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= fms_pkg::CNT_ZERO;
			rx_ff <= '0;
			tog_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			rx_ff <= nxt_rx;
			tog_ff <= nxt_tog;
		end
	end

	// Status word is frozen in the core while chip select is low,
	// so reading it here across domains is safe. Top bit reads zero.
	always_ff @(negedge spi_sclk or negedge sclk_arst_n) begin
		if (!sclk_arst_n) begin
			sdo_ff <= 1'b0;
		end else begin
			sdo_ff <= stat_ff[~cnt_ff];
		end
	end

	// Pin synchronisers
	logic [PW-1:0] pins;
	assign pins = {~spi_cs_n, active_low_reset_pin_n, wake_state, wake_by_reset,
		battery_supply_ok, logic_supply_ok, ground_ok, limp_request,
		direct_channel_inputs};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			tog_s1_ff <= 1'b0;
			tog_s2_ff <= 1'b0;
		end else begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
			tog_s1_ff <= tog_ff;
			tog_s2_ff <= tog_s1_ff;
		end
	end

	logic cs_act_s;
	logic rstpin_n_s;
	logic wake_s;
	logic wbr_s;
	logic battery_supply_s;
	logic vcc_s;
	logic gnd_s;
	logic limp_s;
	logic [NUM_IN-1:0] dir_s;
	assign cs_act_s = sync2_ff[PW-1];
	assign rstpin_n_s = sync2_ff[PW-2];
	assign wake_s = sync2_ff[PW-3];
	assign wbr_s = sync2_ff[PW-4];
	assign battery_supply_s = sync2_ff[PW-5];
	assign vcc_s = sync2_ff[PW-6];
	assign gnd_s = sync2_ff[PW-7];
	assign limp_s = sync2_ff[PW-8];
	assign dir_s = sync2_ff[NUM_IN-1:0];

	// Channels without a direct input stay off in Fail mode
	logic [NUM_CH-1:0] dir_ch;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_dir
			if (gi < NUM_IN) begin : g_in
				assign dir_ch[gi] = dir_s[gi];
			end else begin : g_off
				assign dir_ch[gi] = 1'b0;
			end
		end
	endgenerate

	// Frame checks
	logic off_c;
	logic frame_end;
	logic has_edges;
	logic frame_evt;
	logic len_ok;
	logic wd_bit;
	logic len_err;
	logic tog_err;
	logic good;
	logic timeout;
	logic comm_fault;
	logic exit_ok;
	logic [WW-1:0] wd_end;

	assign off_c = ~battery_supply_s & ~vcc_s;
	assign frame_end = cs_d_ff & ~cs_act_s;
	assign has_edges = tog_s2_ff != tog_seen_ff;
	// Link counters are idle once chip select is high; read directly
	assign frame_evt = frame_end & has_edges & vcc_s;
	assign len_ok = cnt_ff == fms_pkg::CNT_ZERO;
	assign wd_bit = rx_ff[fms_pkg::WD_POS];
	assign len_err = frame_evt & ~len_ok;
	assign tog_err = frame_evt & len_ok & have_ref_ff & (wd_bit == ref_ff);
	assign good = frame_evt & len_ok & ~tog_err;
	assign wd_end = watchdog_period_select ? WD_LONG_END : WD_SHORT_END;
	// At-or-above, so a shorter period chosen mid-count still expires
	assign timeout = wd_ff >= wd_end;
	assign comm_fault = len_err | tog_err | timeout;
	assign exit_ok = ~limp_filt_ff & ~comm_fault & (~flag_ff | good);

	// Timer restarts on good frames and after each expiry
	assign nxt_wd = (off_c | good | timeout) ? '0 : wd_ff + 1'b1;

	// Symmetric deglitch of the fail request
	always_comb begin
		nxt_dgl = '0;
		nxt_limp_filt = limp_filt_ff;
		if (off_c) begin
			nxt_limp_filt = 1'b0;
		end else if (limp_s != limp_filt_ff) begin
			if (dgl_ff == DGL_END) begin
				nxt_limp_filt = limp_s;
			end else begin
				nxt_dgl = dgl_ff + 1'b1;
			end
		end
	end

	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			fms_pkg::MODE_OFF: begin
				if (!off_c) begin
					nxt_mode = fms_pkg::MODE_NORMAL;
				end
			end
			fms_pkg::MODE_NORMAL: begin
				if (off_c) begin
					nxt_mode = fms_pkg::MODE_OFF;
				end else if (comm_fault || limp_filt_ff) begin
					nxt_mode = fms_pkg::MODE_FAIL;
				end
			end
			fms_pkg::MODE_FAIL: begin
				if (off_c) begin
					nxt_mode = fms_pkg::MODE_OFF;
				end else if (exit_ok) begin
					nxt_mode = fms_pkg::MODE_NORMAL;
				end
			end
			default: begin
				nxt_mode = fms_pkg::MODE_OFF;
			end
		endcase
	end

	// A fault in the exit cycle blocks the exit, so set wins over clear
	always_comb begin
		nxt_flag = flag_ff;
		if (off_c) begin
			nxt_flag = 1'b0;
		end else if (comm_fault) begin
			nxt_flag = 1'b1;
		end else if (mode_ff == fms_pkg::MODE_FAIL && exit_ok) begin
			nxt_flag = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= fms_pkg::MODE_OFF;
			flag_ff <= 1'b0;
			wd_ff <= '0;
			dgl_ff <= '0;
			limp_filt_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			flag_ff <= nxt_flag;
			wd_ff <= nxt_wd;
			dgl_ff <= nxt_dgl;
			limp_filt_ff <= nxt_limp_filt;
		end
	end

	logic nxt_ref;
	logic nxt_have_ref;
	assign nxt_ref = off_c ? 1'b0 : (good ? wd_bit : ref_ff);
	assign nxt_have_ref = ~off_c & (have_ref_ff | good);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_ff <= 1'b0;
			have_ref_ff <= 1'b0;
			cs_d_ff <= 1'b0;
			tog_seen_ff <= 1'b0;
		end else begin
			ref_ff <= nxt_ref;
			have_ref_ff <= nxt_have_ref;
			cs_d_ff <= cs_act_s;
			tog_seen_ff <= frame_end ? tog_s2_ff : tog_seen_ff;
		end
	end

	// Status word, held steady while a frame is in progress
	logic is_fail;
	logic [SW-1:0] stat_word;
	logic [SW-1:0] nxt_stat;
	assign is_fail = mode_ff == fms_pkg::MODE_FAIL;
	// Order follows ST_FLAG, ST_LIMP, ST_FAIL, ST_FLT_LO upward
	assign stat_word = {{fms_pkg::ST_PAD{1'b0}}, fault_types, is_fail, limp_s, flag_ff};
	assign nxt_stat = cs_act_s ? stat_ff : stat_word;

	// Output steering
	logic [NUM_CH-1:0] nxt_ch;
	logic nxt_ext;
	logic nxt_clk_oe;
	logic nxt_sdo_oe;
	logic ch_kill;
	assign ch_kill = off_c | ~battery_supply_s | ~gnd_s;
	assign nxt_ch = ch_kill ? '0 : (is_fail ? dir_ch : pwm_channels);
	// External switch is pulled down outside Normal mode
	assign nxt_ext = ~off_c & gnd_s & vcc_s & ~is_fail & ext_switch_setting;
	assign nxt_clk_oe = ~rstpin_n_s & wake_s & ~wbr_s & battery_supply_s;
	assign nxt_sdo_oe = cs_act_s & vcc_s;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_ff <= '0;
			ch_ff <= '0;
			ext_ff <= 1'b0;
			clk_oe_ff <= 1'b0;
			sdo_oe_ff <= 1'b0;
			fail_ff <= 1'b0;
			limp_st_ff <= 1'b0;
			off_ff <= 1'b1;
		end else begin
			stat_ff <= nxt_stat;
			ch_ff <= nxt_ch;
			ext_ff <= nxt_ext;
			clk_oe_ff <= nxt_clk_oe;
			sdo_oe_ff <= nxt_sdo_oe;
			fail_ff <= is_fail;
			limp_st_ff <= limp_s;
			off_ff <= off_c;
		end
	end

	assign spi_sdo = sdo_ff;
	assign spi_sdo_oe = sdo_oe_ff;
	assign power_channel_outputs = ch_ff;
	assign external_switch_drive = ext_ff;
	assign wake_clk_o = clk_oe_ff;
	assign wake_clk_oe = clk_oe_ff;
	assign link_fault_flag = flag_ff;
	assign fail_mode = fail_ff;
	assign limp_status = limp_st_ff;
	assign power_off = off_ff;

endmodule : fms_supervisor

// ===== dv/fms_host.sv
// Host side of the serial link, 12 ns link clock only inside frames
`timescale 1ns/1ps
module fms_host (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic [15:0] rx;
	logic oe_seen;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b1;
		rx = 16'h0000;
		oe_seen = 1'b0;
	end
	// Word MSB first; caller inverts bit 15 per good frame
	task automatic xfer(input int n, input logic [15:0] w);
		// Offset keeps link edges clear of the core clock edges
		#3 cs_n = 1'b0;
		oe_seen = 1'b0;
		#50;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = w[i % 16];
			#6 sclk = 1'b1;
			rx = {rx[14:0], sdo};
			oe_seen = oe_seen | sdo_oe;
			#6 sclk = 1'b0;
		end
		#50 cs_n = 1'b1;
		// Released line must not keep its last level
		sdi = ~sdi;
		#60;
	endtask : xfer
endmodule : fms_host

// ===== dv/fms_supervisor_sva.sv
// Port assertions for the fail mode supervisor
`timescale 1ns/1ps
module fms_supervisor_sva #(
	parameter int NUM_CH = fms_pkg::NUM_CH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic spi_sdo_oe,
	input wire logic active_low_reset_pin_n,
	input wire logic wake_state,
	input wire logic wake_by_reset,
	input wire logic battery_supply_ok,
	input wire logic logic_supply_ok,
	input wire logic ground_ok,
	input wire logic limp_request,
	input wire logic [NUM_CH-1:0] power_channel_outputs,
	input wire logic external_switch_drive,
	input wire logic wake_clk_o,
	input wire logic wake_clk_oe,
	input wire logic link_fault_flag,
	input wire logic fail_mode,
	input wire logic limp_status,
	input wire logic power_off
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Three cycles of margin cover the sync stages
	a_off_dark: assert property (
		power_off [*3] |-> $past(power_channel_outputs == '0 && !external_switch_drive))
		else $error("outputs on in power off");
	a_batt_dark: assert property (
		(!battery_supply_ok) [*5] |-> power_channel_outputs == '0 && !wake_clk_oe)
		else $error("battery loss not handled");
	a_gnd_dark: assert property (
		(!ground_ok) [*5] |-> power_channel_outputs == '0)
		else $error("channels on without ground");
	a_flag_fail: assert property (
		$rose(link_fault_flag) |=> fail_mode)
		else $error("fault without fail mode");
	a_flag_exit: assert property (
		$fell(link_fault_flag) |=> !fail_mode)
		else $error("flag dropped inside fail mode");
	a_fail_outs: assert property (
		fail_mode [*3] |-> $past(!power_channel_outputs[NUM_CH-1] && !external_switch_drive))
		else $error("undriven channel on in fail mode");
	a_sdo_quiet: assert property (
		(!logic_supply_ok) [*5] |-> !spi_sdo_oe)
		else $error("serial out driven without logic supply");
	a_limp_shown: assert property (
		limp_request [*5] |-> limp_status)
		else $error("fail request level not shown");
	a_wake_drive: assert property (
		(!active_low_reset_pin_n && wake_state && !wake_by_reset && battery_supply_ok) [*5]
		|-> wake_clk_oe && wake_clk_o)
		else $error("wake not reported");
	a_wake_quiet: assert property (
		(!wake_state || wake_by_reset) [*5] |-> !wake_clk_oe)
		else $error("clock pin driven while asleep");
endmodule : fms_supervisor_sva
bind fms_supervisor fms_supervisor_sva #(.NUM_CH(NUM_CH)) u_sva (
	.clk(clk), .arst_n(arst_n), .spi_sdo_oe(spi_sdo_oe),
	.active_low_reset_pin_n(active_low_reset_pin_n), .wake_state(wake_state),
	.wake_by_reset(wake_by_reset), .battery_supply_ok(battery_supply_ok),
	.logic_supply_ok(logic_supply_ok), .ground_ok(ground_ok), .limp_request(limp_request),
	.power_channel_outputs(power_channel_outputs), .external_switch_drive(external_switch_drive),
	.wake_clk_o(wake_clk_o), .wake_clk_oe(wake_clk_oe), .link_fault_flag(link_fault_flag),
	.fail_mode(fail_mode), .limp_status(limp_status), .power_off(power_off));

// ===== dv/fail_mode_supervisor_test.sv
// Bench for the fail mode supervisor
`timescale 1ns/1ps
module fail_mode_supervisor_test;
	localparam int DGL = 20;
	localparam int WDS = 2000;
	localparam int WDL = 4000;
	logic clk, arst_n, sclk, cs_n, sdi, sdo, oe, rpin_n, wake, wrst, batt, vlog, gnd;
	logic limp, ext_set, wsel, tog, ext, wclk, wclk_oe, flag, fail, lst, poff;
	logic [3:0] din;
	logic [4:0] pwm, ch;
	logic [7:0] flt;
	int failures, compares;
	fms_supervisor #(.LIMP_DGL_CYC(DGL), .WD_SHORT_CYC(WDS), .WD_LONG_CYC(WDL)) u_dut (
		.clk(clk), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
		.spi_sdo(sdo), .spi_sdo_oe(oe), .active_low_reset_pin_n(rpin_n), .wake_state(wake),
		.wake_by_reset(wrst), .battery_supply_ok(batt), .logic_supply_ok(vlog),
		.ground_ok(gnd), .limp_request(limp), .direct_channel_inputs(din),
		.pwm_channels(pwm), .ext_switch_setting(ext_set), .watchdog_period_select(wsel),
		.fault_types(flt), .power_channel_outputs(ch), .external_switch_drive(ext),
		.wake_clk_o(wclk), .wake_clk_oe(wclk_oe), .link_fault_flag(flag),
		.fail_mode(fail), .limp_status(lst), .power_off(poff));
	fms_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(oe));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Good frame inverts the toggle, a bad one repeats it
	task automatic frame(input logic good, input int n);
		tog = tog ^ good;
		u_host.xfer(n, {tog, 15'h0000});
		cyc(2);
	endtask : frame
	task automatic print_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Whole sequence needs well under ten thousand cycles
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		print_verdict();
	end
	initial begin
		arst_n = 1'b0;
		{rpin_n, wrst, limp, ext_set, wsel, tog} = 6'h00;
		{wake, batt, vlog, gnd} = 4'hF;
		din = 4'hA;
		pwm = 5'h15;
		flt = 8'hA5;
		failures = 0;
		compares = 0;
		cyc(20);
		arst_n <= 1'b1;
		cyc(8);
		chk("power_off", 16'h0000, poff);
		chk("wake_clk", 16'h0003, {wclk, wclk_oe});
		chk("channels", 16'h0015, ch);
		frame(1'b1, 16);
		frame(1'b1, 16);
		chk("flag", 16'h0000, flag);
		chk("sdo_oe", 16'h0001, u_host.oe_seen);
		chk("status", 16'h0528, u_host.rx);
		frame(1'b0, 16);
		chk("flag", 16'h0001, flag);
		chk("fail", 16'h0001, fail);
		chk("channels", 16'h000A, ch);
		frame(1'b0, 16);
		chk("status", 16'h052D, u_host.rx);
		chk("flag", 16'h0001, flag);
		frame(1'b1, 16);
		chk("flag", 16'h0000, flag);
		chk("fail", 16'h0000, fail);
		frame(1'b0, 15);
		chk("flag", 16'h0001, flag);
		frame(1'b1, 16);
		cyc(WDS - 40);
		chk("flag", 16'h0000, flag);
		cyc(80);
		chk("flag", 16'h0001, flag);
		frame(1'b1, 16);
		wsel <= 1'b1;
		frame(1'b1, 16);
		vlog <= 1'b0;
		frame(1'b0, 16);
		chk("flag", 16'h0000, flag);
		chk("sdo_oe", 16'h0000, u_host.oe_seen);
		cyc(WDL - 80);
		chk("flag", 16'h0000, flag);
		cyc(120);
		chk("flag", 16'h0001, flag);
		{vlog, wsel} <= 2'b10;
		cyc(4);
		frame(1'b1, 16);
		limp <= 1'b1;
		cyc(DGL / 2);
		chk("limp_status", 16'h0001, lst);
		limp <= 1'b0;
		cyc(DGL + 8);
		chk("fail", 16'h0000, fail);
		limp <= 1'b1;
		cyc(DGL + 8);
		chk("fail", 16'h0001, fail);
		chk("flag", 16'h0000, flag);
		limp <= 1'b0;
		cyc(DGL + 8);
		chk("fail", 16'h0000, fail);
		ext_set <= 1'b1;
		batt <= 1'b0;
		cyc(6);
		chk("channels", 16'h0000, ch);
		chk("ext", 16'h0001, ext);
		chk("wake_clk", 16'h0000, wclk_oe);
		{batt, wrst} <= 2'b11;
		cyc(6);
		chk("wake_clk", 16'h0000, wclk_oe);
		gnd <= 1'b0;
		cyc(6);
		chk("channels", 16'h0000, ch);
		gnd <= 1'b1;
		frame(1'b0, 16);
		{batt, vlog} <= 2'b00;
		cyc(6);
		chk("power_off", 16'h0001, poff);
		chk("flag", 16'h0000, flag);
		print_verdict();
	end
endmodule : fail_mode_supervisor_test
